// File: hw/ida_pkg.sv
// Purpose : Shared constants and types for the indirect addressing and status block
// Assumes : One core clock, synchronous active-high reset, 12-bit data space
// Notes   : Map of pointer ports, pointer bytes and status register lives here
//
// Behaviour
// - Three independent 12-bit pointers, each held as high and low bytes.
// - Plain port accesses memory at pointer address; pointer unchanged.
// - Post-decrement port uses pointer, then decrements it by one.
// - Post-increment port uses pointer, then increments it by one.
// - Pre-increment port increments pointer first, then uses new value.
// - Offset port adds signed accumulator to pointer; neither changes.
// - Pointer steps act on all twelve bits, carrying into the high byte.
// - Pointer steps never touch any status flag.
// - Indirect read of a port location gives zero, sets zero flag; write ignored.
// - Indirect write to a pointer byte beats that pointer's own auto step.
// - Status write from flag-updating instruction loses to ALU-produced flags.
// - Status bits 7..5 read zero; bits 4..0 are N, V, Z, half-carry, carry.
// - Negative flag copies result bit seven.
// - Signed wrap flag set when signed result overflows into bit seven.
// - Zero flag set when the result is zero, cleared otherwise.
// - Half-carry is carry out of bit three; rotate left loads source bit 3, rotate right bit 4.
// - Carry is carry out of bit seven; rotates load source high or low bit.
// - Subtract adds two's complement, so carries act as inverted borrows.
// - Unimplemented bank reads zero and ignores writes; flags act normally.

package ida_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int          NUM_PTR     = 3;
  localparam int          MEM_BYTES   = 4096;
  localparam logic [4:0]  IMPL_BANKS  = 5'h10;    // Banks of 256 bytes present

  // ----------------------------------------------------------------------
  // Address map (12-bit data space)
  // ----------------------------------------------------------------------
  localparam logic [11:0] PORT_BASE   = 12'hfe0;  // Eight locations per pointer
  localparam logic [11:0] PORT_LIMIT  = 12'hff8;  // First address past the block
  localparam logic [11:0] STATUS_ADDR = 12'hfd8;
  localparam logic [2:0]  SUB_PLAIN   = 3'h0;
  localparam logic [2:0]  SUB_DEC     = 3'h1;
  localparam logic [2:0]  SUB_INC     = 3'h2;
  localparam logic [2:0]  SUB_PRE     = 3'h3;
  localparam logic [2:0]  SUB_OFS     = 3'h4;
  localparam logic [2:0]  SUB_LOW     = 3'h5;
  localparam logic [2:0]  SUB_HIGH    = 3'h6;

  // ----------------------------------------------------------------------
  // Status field positions and reset values
  // ----------------------------------------------------------------------
  localparam int          FLG_C       = 0;
  localparam int          FLG_DC      = 1;
  localparam int          FLG_Z       = 2;
  localparam int          FLG_OV      = 3;
  localparam int          FLG_N       = 4;
  localparam logic [4:0]  STATUS_RST  = 5'h00;
  localparam logic [2:0]  STATUS_PAD  = 3'h0;
  localparam logic [11:0] PTR_RST     = 12'h000;
  localparam logic [3:0]  HIGH_PAD    = 4'h0;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    IDA_ADD, IDA_ADDC, IDA_SUB, IDA_LOGIC, IDA_RLC, IDA_RRC, IDA_NONE
  } ida_alu_op_type;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } ida_bus_req_type;

  typedef struct packed {
    ida_alu_op_type op;
    logic [7:0]     a;
    logic [7:0]     b;
    logic           valid;
  } ida_alu_req_type;

  typedef struct packed {
    logic [7:0] result;
    logic [4:0] flags;
    logic [4:0] mask;
  } ida_alu_res_type;

endpackage

// File: hw/ida_data_ram.sv
// Purpose : Byte-wide data memory of the 12-bit data space
// Assumes : Synchronous read, data one cycle after the address
// Notes   : Banks at or above IMPL_BANKS are absent

`timescale 1ns/100ps

module ida_data_ram
  import ida_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // Access
  input  wire logic        i_wr,
  input  wire logic [11:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata
);

  logic [7:0] mem [0:MEM_BYTES-1];

  wire bank_ok = {1'b0, i_addr[11:8]} < IMPL_BANKS;

  // Storage write, absent banks ignore it
  always_ff @(posedge i_clk_sys) begin
    if (i_wr && bank_ok) begin
      mem[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rdata <= ZERO_BYTE;
    end else begin
      o_rdata <= bank_ok ? mem[i_addr] : ZERO_BYTE;
    end
  end

endmodule

// File: hw/ida_alu_flags.sv
// Purpose : Arithmetic result and the five status flags it produces
// Assumes : Pure combinational, carry input taken from the status register
// Notes   : Mask marks which flags the operation updates

`timescale 1ns/100ps

module ida_alu_flags
  import ida_pkg::*;
(
  // Operation
  input  wire ida_alu_req_type i_req,
  input  wire logic            i_carry,
  // Result
  output ida_alu_res_type      o_res
);

  logic [7:0] b_eff;
  logic       cin;
  logic [8:0] sum;
  logic [4:0] half;

  assign b_eff = (i_req.op == IDA_SUB) ? ~i_req.b : i_req.b;
  assign cin   = (i_req.op == IDA_SUB) ? 1'b1 : ((i_req.op == IDA_ADDC) ? i_carry : 1'b0);
  assign sum   = {1'b0, i_req.a} + {1'b0, b_eff} + {8'h00, cin};
  assign half  = {1'b0, i_req.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};

  // Flag generation per operation class
  always_comb begin
    o_res = '0;
    case (i_req.op)
      IDA_ADD, IDA_ADDC, IDA_SUB: begin
        o_res.result        = sum[7:0];
        o_res.flags[FLG_C]  = sum[8];
        o_res.flags[FLG_DC] = half[4];
        o_res.flags[FLG_OV] = (i_req.a[7] == b_eff[7]) && (sum[7] != i_req.a[7]);
        o_res.mask          = 5'h1f;
      end
      IDA_RLC: begin
        o_res.result        = {i_req.a[6:0], i_carry};
        o_res.flags[FLG_C]  = i_req.a[7];
        o_res.flags[FLG_DC] = i_req.a[3];
        o_res.mask          = 5'h17;
      end
      IDA_RRC: begin
        o_res.result        = {i_carry, i_req.a[7:1]};
        o_res.flags[FLG_C]  = i_req.a[0];
        o_res.flags[FLG_DC] = i_req.a[4];
        o_res.mask          = 5'h17;
      end
      IDA_LOGIC: begin
        o_res.result = i_req.a;
        o_res.mask   = 5'h14;
      end
      default: begin
        o_res.result = i_req.a;
        o_res.mask   = 5'h00;
      end
    endcase
    o_res.flags[FLG_Z] = (o_res.result == ZERO_BYTE);
    o_res.flags[FLG_N] = o_res.result[7];
  end

endmodule

// File: hw/ida_indirect_status.sv
// Purpose : Pointer registers, indirect access ports and ALU status register
// Assumes : Core issues one access per cycle; read data one cycle later
// Notes   : Pointer steps take effect on the edge of the access itself

`timescale 1ns/100ps

module ida_indirect_status (
  // Clock and reset
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_rst,
  // Data access from instruction execution
  input  wire ida_pkg::ida_bus_req_type i_bus,
  output logic                  [7:0]  o_rd_data,
  // Accumulator for the offset port
  input  wire logic             [7:0]  i_accum,
  // ALU operation of the current instruction
  input  wire ida_pkg::ida_alu_req_type i_alu,
  output logic                  [7:0]  o_alu_result,
  // Status observation
  output logic                  [7:0]  o_status
);
  import ida_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [11:0]     ptr [NUM_PTR];
  logic [4:0]      status;
  logic [4:0]      next_status;
  logic [7:0]      reg_q;
  logic            mem_sel_q;
  logic [7:0]      ram_rdata;
  ida_alu_res_type alu_res;

  // Block membership test for the port area
  function automatic logic fn_in_blk(input logic [11:0] a);
    return (a >= PORT_BASE) && (a < PORT_LIMIT);
  endfunction

  // ----------------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------------
  wire         access   = i_bus.wr | i_bus.rd;
  wire [1:0]   dir_idx  = i_bus.addr[4:3];
  wire [2:0]   dir_sub  = i_bus.addr[2:0];
  wire         via_port = fn_in_blk(i_bus.addr) && (dir_sub <= SUB_OFS);
  wire [11:0]  sel_ptr  = via_port ? ptr[dir_idx] : PTR_RST;

  wire [11:0]  ofs_sum  = sel_ptr + {{4{i_accum[7]}}, i_accum};
  wire [11:0]  pre_sum  = sel_ptr + 12'h001;

  wire [11:0]  eff_addr = !via_port             ? i_bus.addr :
                          (dir_sub == SUB_PRE) ? pre_sum    :
                          (dir_sub == SUB_OFS) ? ofs_sum    : sel_ptr;

  // Target of the effective address
  wire [1:0]   eff_idx    = eff_addr[4:3];
  wire [2:0]   eff_sub    = eff_addr[2:0];
  wire         eff_blk    = fn_in_blk(eff_addr);
  wire         eff_low    = eff_blk && (eff_sub == SUB_LOW);
  wire         eff_high   = eff_blk && (eff_sub == SUB_HIGH);
  wire         eff_status = (eff_addr == STATUS_ADDR);
  wire         eff_mem    = !eff_blk && !eff_status;
  // pointer aims at a port location
  wire         eff_virt   = via_port && eff_blk && (eff_sub <= SUB_OFS);
  wire         wr_ok      = i_bus.wr && !eff_virt;
  wire         zero_force = i_bus.rd && eff_virt;

  // ----------------------------------------------------------------------
  // Pointer registers
  // ----------------------------------------------------------------------
  // one 12-bit pointer per index
  genvar p;
  generate
    for (p = 0; p < NUM_PTR; p = p + 1) begin : g_ptr
      logic [11:0] next_ptr;
      wire         hit_low  = wr_ok && eff_low  && (eff_idx == 2'(p));
      wire         hit_high = wr_ok && eff_high && (eff_idx == 2'(p));
      wire         own_port = access && via_port && (dir_idx == 2'(p));

      // Byte load or automatic step
      always_comb begin
        next_ptr = ptr[p];
        if (hit_low) begin
          next_ptr = {ptr[p][11:8], i_bus.wdata};
        end else if (hit_high) begin
          next_ptr = {i_bus.wdata[3:0], ptr[p][7:0]};
        end else if (own_port) begin
          case (dir_sub)
            SUB_DEC: next_ptr = ptr[p] - 12'h001;
            SUB_INC: next_ptr = ptr[p] + 12'h001;
            SUB_PRE: next_ptr = ptr[p] + 12'h001;
            default: next_ptr = ptr[p];
          endcase
        end
      end

      always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
          ptr[p] <= PTR_RST;
        end else begin
          ptr[p] <= next_ptr;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------------
  ida_alu_flags u_alu (
    .i_req   (i_alu),
    .i_carry (status[FLG_C]),
    .o_res   (alu_res)
  );

  // Data write, forced zero, then ALU flags on top
  always_comb begin
    next_status = status;
    if (wr_ok && eff_status) begin
      next_status = i_bus.wdata[4:0];
    end
    if (zero_force) begin
      next_status[FLG_Z] = 1'b1;
    end
    if (i_alu.valid) begin
      next_status = (next_status & ~alu_res.mask) | (alu_res.flags & alu_res.mask);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      status <= STATUS_RST;
    end else begin
      status <= next_status;
    end
  end

  // ALU result to the core
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_alu_result <= ZERO_BYTE;
    end else begin
      o_alu_result <= alu_res.result;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_status <= {STATUS_PAD, STATUS_RST};
    end else begin
      o_status <= {STATUS_PAD, next_status};
    end
  end

  // ----------------------------------------------------------------------
  // Data memory and read path
  // ----------------------------------------------------------------------
  ida_data_ram u_ram (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_wr      (wr_ok && eff_mem),
    .i_addr    (eff_addr),
    .i_wdata   (i_bus.wdata),
    .o_rdata   (ram_rdata)
  );

  // pointer bytes readable, high nibble zero
  wire [7:0] reg_rdata = eff_low    ? ptr[eff_idx][7:0]                :
                         eff_high   ? {HIGH_PAD, ptr[eff_idx][11:8]}   :
                         eff_status ? {STATUS_PAD, status}             : ZERO_BYTE;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      reg_q     <= ZERO_BYTE;
      mem_sel_q <= 1'b0;
    end else begin
      reg_q     <= eff_virt ? ZERO_BYTE : reg_rdata;
      mem_sel_q <= i_bus.rd && eff_mem && !eff_virt;
    end
  end

  // Read data stands in the cycle after the read strobe
  assign o_rd_data = mem_sel_q ? ram_rdata : reg_q;

endmodule

// File: sim/ida_is_assertions.sv
// Purpose : Port-level checks of the pointer and status block
// Assumes : One clock domain, synchronous active-high reset
// Notes   : Bound onto ida_indirect_status

`timescale 1ns/100ps

module ida_is_checker (
  // Clock and reset
  input wire logic                     i_clk_sys,
  input wire logic                     i_rst,
  // Observed ports
  input wire ida_pkg::ida_bus_req_type i_bus,
  input wire logic [7:0]               o_rd_data,
  input wire logic [7:0]               i_accum,
  input wire ida_pkg::ida_alu_req_type i_alu,
  input wire logic [7:0]               o_alu_result,
  input wire logic [7:0]               o_status
);
  import ida_pkg::*;

  // --------------------------------------------------------------------
  // Reference arithmetic
  // --------------------------------------------------------------------
  wire [8:0] sum    = {1'b0, i_alu.a} + {1'b0, i_alu.b};
  wire [4:0] half   = {1'b0, i_alu.a[3:0]} + {1'b0, i_alu.b[3:0]};
  wire       is_add = i_alu.valid && (i_alu.op == IDA_ADD);
  wire       is_sub = i_alu.valid && (i_alu.op == IDA_SUB);
  wire       is_lgc = i_alu.valid && (i_alu.op == IDA_LOGIC);

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  a_status_pad: assert property (o_status[7:5] == 3'h0)
    else $error("status upper bits not zero");
  a_reset_clear: assert property (disable iff (1'b0) i_rst |=> o_status == 8'h00)
    else $error("status not cleared by reset");
  a_port_read: assert property ((i_bus.rd && i_bus.addr == 12'hfe7) |=> o_rd_data == 8'h00)
    else $error("reserved port read not zero");
  a_neg_copy: assert property (is_add |=> o_status[FLG_N] == $past(sum[7]))
    else $error("negative flag wrong");
  a_zero_logic: assert property (is_lgc |=> o_status[FLG_Z] == $past(i_alu.a == 8'h00))
    else $error("zero flag wrong");
  a_carry_add: assert property (is_add |=> o_status[FLG_C] == $past(sum[8]))
    else $error("carry flag wrong");
  a_borrow_sub: assert property (is_sub |=> o_status[FLG_C] == $past(i_alu.a >= i_alu.b))
    else $error("borrow polarity wrong");
  a_half_add: assert property (is_add |=> o_status[FLG_DC] == $past(half[4]))
    else $error("half carry wrong");
endmodule

bind ida_indirect_status ida_is_checker chk_u (.i_clk_sys, .i_rst, .i_bus, .o_rd_data,
  .i_accum, .i_alu, .o_alu_result, .o_status);

// File: sim/ida_core_model.sv
// Purpose : Instruction-side model issuing data and ALU requests
// Assumes : Read data stands only in the cycle after the strobe
// Notes   : Signals change by non-blocking assignment after an edge

`timescale 1ns/100ps

module ida_core_model
  import ida_pkg::*;
(
  // Clock and read return
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_rd_data,
  // Requests toward the block
  output ida_bus_req_type o_bus,
  output logic      [7:0] o_accum,
  output ida_alu_req_type o_alu
);
  localparam ida_bus_req_type IDLE = '0;
  localparam ida_alu_req_type NOP  = '{IDA_NONE, 8'h00, 8'h00, 1'b0};

  // Quiet bus until the first request
  initial begin
    o_bus   = IDLE;
    o_accum = 8'h00;
    o_alu   = NOP;
  end

  // One-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clk_sys);
    o_bus <= IDLE;
    #1; // Let the write's edge settle before callers look
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    o_bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_clk_sys);
    o_bus <= IDLE;
    #1 d = i_rd_data;
  endtask

  // Flag-updating operation that also writes the status register
  task automatic alu(input ida_alu_op_type op, input logic [7:0] a, input logic [7:0] b,
                     input logic [7:0] w);
    @(posedge i_clk_sys);
    o_alu <= '{op, a, b, 1'b1};
    o_bus <= '{STATUS_ADDR, w, 1'b1, 1'b0};
    @(posedge i_clk_sys);
    o_alu <= NOP;
    o_bus <= IDLE;
    #1;
  endtask
endmodule

// File: sim/ida_indirect_status_tb_top.sv
// Purpose : Self-checking bench for pointers, ports and status flags
// Assumes : 200 MHz clock, reset held ten cycles
// Notes   : Pointer p ports sit at 0xfe0 + 8p

`timescale 1ns/100ps

module ida_indirect_status_tb_top;
  import ida_pkg::*;

  logic            clk_sys  = 1'b0;
  logic            rst      = 1'b1;
  int              n_errors = 0;
  int              compares = 0;
  logic      [7:0] d;
  logic      [7:0] rdat;
  logic      [7:0] acc;
  logic      [7:0] ares;
  logic      [7:0] stat;
  ida_bus_req_type bus;
  ida_alu_req_type alu;

  // Core clock
  always #2.5 clk_sys = ~clk_sys;

  ida_indirect_status dut_u (.i_clk_sys(clk_sys), .i_rst(rst), .i_bus(bus), .o_rd_data(rdat),
    .i_accum(acc), .i_alu(alu), .o_alu_result(ares), .o_status(stat));
  ida_core_model cm (.i_clk_sys(clk_sys), .i_rd_data(rdat), .o_bus(bus), .o_accum(acc),
    .o_alu(alu));

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    cm.rd(a, d);
    chk($sformatf("read %h", a), e, d);
  endtask

  task automatic ac(input ida_alu_op_type op, input logic [7:0] a, input logic [7:0] b,
                    input logic [7:0] w, input logic [7:0] er, input logic [7:0] es);
    cm.alu(op, a, b, w);
    chk("alu result", er, ares);
    chk("status", es, stat);
  endtask

  task automatic end_of_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_errors++;
    end_of_test();
  end

  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk("reset status", 8'h00, stat);
    cm.wr(12'hfe5, 8'hff);
    cm.wr(12'hfe6, 8'h00);
    cm.wr(12'h0ff, 8'h11);
    cm.wr(12'h100, 8'h22);
    rc(12'hfe2, 8'h11);
    rc(12'hfe0, 8'h22);
    rc(12'hfe6, 8'h01);
    rc(12'hfe0, 8'h22);
    rc(12'hfe1, 8'h22);
    rc(12'hfe0, 8'h11);
    rc(12'hfe3, 8'h22);
    cm.o_accum <= 8'hff;
    rc(12'hfe4, 8'h11);
    rc(12'hfe5, 8'h00);
    cm.o_accum <= 8'h00;
    cm.wr(12'hfe6, 8'hf5);
    rc(12'hfe6, 8'h05);
    rc(12'hfe7, 8'h00);
    cm.wr(STATUS_ADDR, 8'he5);
    rc(STATUS_ADDR, 8'h05);
    cm.wr(12'hfed, 8'he0);
    cm.wr(12'hfee, 8'h0f);
    cm.wr(STATUS_ADDR, 8'h00);
    rc(12'hfe8, 8'h00);
    chk("port read zero flag", 8'h04, stat);
    cm.wr(STATUS_ADDR, 8'h00);
    cm.wr(12'hfe8, 8'h55);
    chk("port write flags", 8'h00, stat);
    cm.wr(12'h001, 8'h33);
    cm.wr(12'hfe5, 8'h01);
    cm.wr(12'hfe6, 8'h00);
    rc(12'hfe1, 8'h33);
    chk("step to zero flags", 8'h00, stat);
    rc(12'hfe5, 8'h00);
    cm.wr(12'hff5, 8'hf5);
    cm.wr(12'hff6, 8'h0f);
    cm.wr(12'hff2, 8'h40);
    rc(12'hff5, 8'h40);
    ac(IDA_ADD, 8'h80, 8'h80, 8'h1f, 8'h00, 8'h0d);
    ac(IDA_ADD, 8'h0f, 8'h01, 8'h1f, 8'h10, 8'h02);
    ac(IDA_SUB, 8'h05, 8'h07, 8'h00, 8'hfe, 8'h10);
    ac(IDA_SUB, 8'h07, 8'h05, 8'h00, 8'h02, 8'h03);
    ac(IDA_RLC, 8'h88, 8'h00, 8'h1c, 8'h11, 8'h0b);
    ac(IDA_RRC, 8'h01, 8'h00, 8'h00, 8'h80, 8'h11);
    ac(IDA_LOGIC, 8'h00, 8'h00, 8'h0b, 8'h00, 8'h0f);
    ac(IDA_ADDC, 8'h01, 8'h01, 8'h00, 8'h03, 8'h00);
    // Mid-run reset must clear status and pointer 2 again
    cm.wr(STATUS_ADDR, 8'h1f);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk("mid-run reset status", 8'h00, stat);
    rc(12'hff5, 8'h00);
    rc(12'hff6, 8'h00);
    end_of_test();
  end
endmodule
